// ### rtl/tcpu_core.sv
// Tiny 8-bit constant-coded CPU core with an AXI4-Lite control slave.
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// How it works
// - Sixteen equal eight-bit general registers.
// - ALU result returns to first operand register.
// - Second operand: register or instruction constant.
// - Add, sub, carry forms, logic, shifts.
// - ALU sets flags; conditions test them.
// - Jump loads absolute address, maybe conditionally.
// - Call pushes, return pops fifteen-deep stack.
// - 256 ports, port address plus strobes.
// - Port address from constant or register.
// - Input copies input byte to register.
// - Input gives one read strobe pulse.
// - Output drives byte with write strobe.
// - One interrupt input, masked after start.
// - Interrupt calls address FF, pushing return.
// - Interrupt saves flags, disables interrupts.
// - Interrupt return restores flags, sets enable from bit 5.
// - Every instruction takes exactly two clocks.
// - 256 by 16 program, 8-bit addresses.
// - Constants live inside the instruction word.
// - Counter advances by one, wraps.
// - Cyclic stack overwrites oldest when full.
// - Return resumes at popped value plus one.
// - Jump, call, return keep flags.
module tcpu_core
  import tcpu_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Program memory.
  input wire logic [15:0] INSTR,
  output logic [7:0] PROG_ADDR,
  // Port bus.
  output logic [7:0] PORT_ID,
  output logic [7:0] OUT_DATA,
  input wire logic [7:0] IN_DATA,
  output logic READ_STROBE,
  output logic WRITE_STROBE,
  // Interrupt request.
  input wire logic INT_REQ,
  // AXI4-Lite write channels.
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels.
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Arithmetic and logic operations; bit 8 carries out or borrows.
  function automatic logic [8:0] alu_calc(
    input logic [2:0] op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic cin
  );
    logic [8:0] r;
    r = 9'h000;
    unique case (op)
      ALU_LOAD: r = {1'b0, b};
      ALU_AND: r = {1'b0, a & b};
      ALU_OR: r = {1'b0, a | b};
      ALU_XOR: r = {1'b0, a ^ b};
      ALU_ADD: r = {1'b0, a} + {1'b0, b};
      ALU_ADDCY: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      ALU_SUB: r = {1'b0, a} - {1'b0, b};
      ALU_SUBCY: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    endcase
    return r;
  endfunction

  // Shift and rotate; bit 3 picks right, bits 2:1 the fill source.
  function automatic logic [8:0] shift_calc(
    input logic [3:0] code,
    input logic [7:0] a,
    input logic cin
  );
    logic fill;
    fill = 1'b0;
    if (code[3])
    begin
      unique case (code[2:1])
        2'h3: fill = code[0];
        2'h1: fill = a[7];
        2'h0: fill = cin;
        2'h2: fill = a[0];
      endcase
      return {a[0], fill, a[7:1]};
    end
    unique case (code[2:1])
      2'h3: fill = code[0];
      2'h2: fill = a[0];
      2'h0: fill = cin;
      2'h1: fill = a[7];
    endcase
    return {a[7], a[6:0], fill};
  endfunction

  // Cyclic stack pointer steps over fifteen slots.
  function automatic logic [3:0] sp_step(input logic [3:0] p, input logic up);
    if (up)
    begin
      return (p == 4'(STACK_DEPTH - 1)) ? 4'h0 : p + 4'h1;
    end
    return (p == 4'h0) ? 4'(STACK_DEPTH - 1) : p - 4'h1;
  endfunction

  tcpu_state_t state;
  tcpu_flags_t flags;
  tcpu_flags_t saved;
  tcpu_flags_t alu_flags;
  tcpu_port_t port;
  logic [7:0] pc;
  logic [7:0] next_pc;
  logic [7:0] regs [0:15];
  logic [7:0] stack [0:STACK_DEPTH-1];
  logic [3:0] sp;
  logic ie;
  logic irq_meta;
  logic irq_sync;
  logic run;
  logic soft_rst;
  logic rd_pend;
  logic wr_pend;
  logic [3:0] io_x;
  logic [3:0] grp;
  logic [3:0] rx;
  logic [3:0] ry;
  logic [7:0] kk;
  logic [7:0] op_b;
  logic [8:0] alu_out;
  logic alu_we;
  logic alu_fw;
  logic is_flow;
  logic cond_ok;
  logic is_ie_op;
  logic is_reti;
  logic is_in;
  logic is_out;
  logic executing;
  logic take_irq;
  logic fire;
  logic push;
  logic pop;
  logic [7:0] push_val;
  logic wr_go;
  logic rd_go;

  // Interrupt request crosses in through two flip-flops.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end
    else
    begin
      irq_meta <= INT_REQ;
      irq_sync <= irq_meta;
    end
  end

  // Instruction fields; constants come straight from the word.
  always_comb
  begin
    grp = INSTR[15:12];
    rx = INSTR[11:8];
    ry = INSTR[7:4];
    kk = INSTR[7:0];
    op_b = (grp == GRP_REG_ALU) ? regs[ry] : kk;
    is_flow = (grp == GRP_FLOW) || (grp == GRP_FLOW_COND);
    is_in = (grp == GRP_IN_CONST) || (grp == GRP_IN_REG);
    is_out = (grp == GRP_OUT_CONST) || (grp == GRP_OUT_REG);
    is_ie_op = (grp == GRP_FLOW) && (INSTR[9:8] == FK_RET) && INSTR[4] && !INSTR[7];
    is_reti = (grp == GRP_FLOW) && (INSTR[9:8] == FK_RET) && INSTR[4] && INSTR[7];
    cond_ok = 1'b1;
    if (grp == GRP_FLOW_COND)
    begin
      unique case (INSTR[11:10])
        CC_Z: cond_ok = flags.zero;
        CC_NZ: cond_ok = !flags.zero;
        CC_C: cond_ok = flags.carry;
        CC_NC: cond_ok = !flags.carry;
      endcase
    end
  end

  // Execution happens in the first phase; an accepted interrupt replaces it.
  always_comb
  begin
    executing = (state == S_EXEC) && run;
    take_irq = executing && ie && irq_sync;
    fire = executing && !take_irq;
  end

  // ALU result and flag update for the constant, register and shift groups.
  always_comb
  begin
    alu_out = 9'h000;
    alu_we = 1'b0;
    alu_fw = 1'b0;
    if (grp[3] == 1'b0)
    begin
      alu_out = alu_calc(grp[2:0], regs[rx], op_b, flags.carry);
      alu_we = 1'b1;
      alu_fw = (grp[2:0] != ALU_LOAD);
    end
    else if ((grp == GRP_REG_ALU) && !INSTR[3])
    begin
      alu_out = alu_calc(INSTR[2:0], regs[rx], op_b, flags.carry);
      alu_we = 1'b1;
      alu_fw = (INSTR[2:0] != ALU_LOAD);
    end
    else if (grp == GRP_SHIFT)
    begin
      alu_out = shift_calc(INSTR[3:0], regs[rx], flags.carry);
      alu_we = 1'b1;
      alu_fw = 1'b1;
    end
    alu_flags.zero = (alu_out[7:0] == 8'h00);
    alu_flags.carry = alu_out[8];
  end

  // Next program counter, stack push and pop.
  always_comb
  begin
    next_pc = pc + 8'h01;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc;
    if (take_irq)
    begin
      next_pc = INT_VECTOR;
      push = 1'b1;
      push_val = pc - 8'h01; // Return plus one resumes the skipped word.
    end
    else if (fire && is_flow && cond_ok)
    begin
      unique case (INSTR[9:8])
        FK_JUMP: next_pc = kk;
        FK_CALL:
        begin
          next_pc = kk;
          push = 1'b1;
        end
        FK_RET:
        begin
          if (!is_ie_op)
          begin
            pop = 1'b1;
            next_pc = stack[sp_step(sp, 1'b0)] + 8'h01;
          end
        end
        default: next_pc = pc + 8'h01;
      endcase
    end
  end

  // Phase sequencer; the port phase also covers the program memory read.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= S_PORT;
    end
    else if (soft_rst)
    begin
      state <= S_PORT;
    end
    else if (run)
    begin
      unique case (state)
        S_EXEC: state <= S_PORT;
        S_PORT: state <= S_EXEC;
        default: state <= S_PORT;
      endcase
    end
  end

  // Program counter.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      pc <= PC_RESET;
    end
    else if (soft_rst)
    begin
      pc <= PC_RESET;
    end
    else if (executing)
    begin
      pc <= next_pc;
    end
  end

  // Interrupt enable.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ie <= 1'b0;
    end
    else if (soft_rst)
    begin
      ie <= 1'b0;
    end
    else if (take_irq)
    begin
      ie <= 1'b0;
    end
    else if (fire && (is_ie_op || is_reti))
    begin
      ie <= INSTR[5];
    end
  end

  // Flags; flow instructions other than the interrupt return leave them alone.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      flags <= '0;
    end
    else if (fire && is_reti)
    begin
      flags <= saved;
    end
    else if (fire && alu_fw)
    begin
      flags <= alu_flags;
    end
  end

  // Flags saved on interrupt entry.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      saved <= '0;
    end
    else if (take_irq)
    begin
      saved <= flags;
    end
  end

  // Stack pointer wraps over the cyclic buffer.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      sp <= 4'h0;
    end
    else if (push)
    begin
      sp <= sp_step(sp, 1'b1);
    end
    else if (pop)
    begin
      sp <= sp_step(sp, 1'b0);
    end
  end

  // Stack storage needs no reset; a full stack overwrites the oldest slot.
  always_ff @(posedge REF_CLK)
  begin
    if (push)
    begin
      stack[sp] <= push_val;
    end
  end

  // General registers take ALU results or the captured input byte.
  always_ff @(posedge REF_CLK)
  begin
    if (fire && alu_we)
    begin
      regs[rx] <= alu_out[7:0];
    end
    else if (rd_pend)
    begin
      regs[io_x] <= IN_DATA;
    end
  end

  // Port address and data are latched in the first phase and strobed in the second.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      port <= '0;
      io_x <= 4'h0;
      rd_pend <= 1'b0;
      wr_pend <= 1'b0;
    end
    else
    begin
      rd_pend <= fire && is_in;
      wr_pend <= fire && is_out;
      if (fire && (is_in || is_out))
      begin
        port.id <= grp[0] ? regs[ry] : kk;
        port.data <= regs[rx];
        io_x <= rx;
      end
    end
  end

  // Port bus outputs all come from flip-flops.
  assign PORT_ID = port.id;
  assign OUT_DATA = port.data;
  assign READ_STROBE = rd_pend;
  assign WRITE_STROBE = wr_pend;
  assign PROG_ADDR = pc;

  // Write address and data are taken together, one write at a time.
  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY = wr_go;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= (S_AXI_AWADDR == REG_CTRL) || (S_AXI_AWADDR == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Control register: run enable and self-clearing soft reset.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      run <= CTRL_RUN_RESET;
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= wr_go && (S_AXI_AWADDR == REG_CTRL) && S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_SRST_BIT];
      if (wr_go && (S_AXI_AWADDR == REG_CTRL) && S_AXI_WSTRB[0])
      begin
        run <= S_AXI_WDATA[CTRL_RUN_BIT];
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  assign rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      S_AXI_RDATA <= 32'h0000_0000;
      if (S_AXI_ARADDR == REG_CTRL)
      begin
        S_AXI_RDATA[CTRL_RUN_BIT] <= run;
      end
      else if (S_AXI_ARADDR == REG_STATUS)
      begin
        S_AXI_RDATA[7:0] <= pc;
        S_AXI_RDATA[STAT_ZERO_BIT] <= flags.zero;
        S_AXI_RDATA[STAT_CARRY_BIT] <= flags.carry;
        S_AXI_RDATA[STAT_IE_BIT] <= ie;
        S_AXI_RDATA[STAT_IRQ_BIT] <= irq_sync;
      end
      else
      begin
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end
    else if (S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Checks on the execution core.
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_strobe_single_pulse: assert property (READ_STROBE |=> !READ_STROBE)
    else $error("read strobe longer than one cycle");
  a_strobe_after_exec: assert property ((READ_STROBE || WRITE_STROBE) |-> $past(state == S_EXEC) && !(READ_STROBE && WRITE_STROBE))
    else $error("strobe outside the port phase");
  a_input_captured: assert property (READ_STROBE |=> regs[io_x] == $past(IN_DATA))
    else $error("input byte not captured");
  a_pc_two_cycle: assert property ((executing && !soft_rst) |=>
    pc == $past(next_pc) ##1 ($past(soft_rst) || pc == $past(pc)))
    else $error("counter moved other than once per two cycles");
  a_pc_advance: assert property ((fire && !is_flow && !soft_rst) |=> pc == $past(pc) + 8'h01)
    else $error("counter did not advance by one");
  a_irq_vector: assert property ((take_irq && !soft_rst) |=> pc == INT_VECTOR && !ie && saved == $past(flags))
    else $error("interrupt entry wrong");
  a_flow_keeps_flags: assert property ((fire && is_flow && !is_reti) |=> flags == $past(flags))
    else $error("flow instruction changed flags");
  a_call_return: assert property ((fire && is_flow && cond_ok && INSTR[9:8] == FK_CALL && !soft_rst) |=>
    stack[sp_step(sp, 1'b0)] == $past(pc) && pc == $past(kk))
    else $error("call did not push and branch");
  a_soft_reset: assert property (soft_rst |=> pc == PC_RESET && !ie && state == S_PORT)
    else $error("soft reset did not restart");

  c_irq_taken: cover property (take_irq ##2 (fire && is_reti));
  c_input_op: cover property (READ_STROBE);
  c_output_op: cover property (WRITE_STROBE);
  c_call_ret: cover property (push ##[2:40] pop);

endmodule

// ### rtl/tcpu_pkg.sv
// Constants, field layouts and types shared by the tiny constant-coded CPU.
package tcpu_pkg;
  // Register map of the AXI4-Lite slave (byte addresses).
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int STAT_ZERO_BIT = 8;
  localparam int STAT_CARRY_BIT = 9;
  localparam int STAT_IE_BIT = 10;
  localparam int STAT_IRQ_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Instruction groups held in the top nibble.
  localparam logic [3:0] GRP_FLOW = 4'h8;
  localparam logic [3:0] GRP_FLOW_COND = 4'h9;
  localparam logic [3:0] GRP_IN_CONST = 4'ha;
  localparam logic [3:0] GRP_IN_REG = 4'hb;
  localparam logic [3:0] GRP_REG_ALU = 4'hc;
  localparam logic [3:0] GRP_SHIFT = 4'hd;
  localparam logic [3:0] GRP_OUT_CONST = 4'he;
  localparam logic [3:0] GRP_OUT_REG = 4'hf;
  // Flow kinds in bits 9:8 and condition codes in bits 11:10.
  localparam logic [1:0] FK_RET = 2'h0;
  localparam logic [1:0] FK_JUMP = 2'h1;
  localparam logic [1:0] FK_CALL = 2'h3;
  localparam logic [1:0] CC_Z = 2'h0;
  localparam logic [1:0] CC_NZ = 2'h1;
  localparam logic [1:0] CC_C = 2'h2;
  localparam logic [1:0] CC_NC = 2'h3;
  // ALU operation codes.
  localparam logic [2:0] ALU_LOAD = 3'h0;
  localparam logic [2:0] ALU_AND = 3'h1;
  localparam logic [2:0] ALU_OR = 3'h2;
  localparam logic [2:0] ALU_XOR = 3'h3;
  localparam logic [2:0] ALU_ADD = 3'h4;
  localparam logic [2:0] ALU_ADDCY = 3'h5;
  localparam logic [2:0] ALU_SUB = 3'h6;
  localparam logic [2:0] ALU_SUBCY = 3'h7;
  // Program counter values and return stack size.
  localparam logic [7:0] PC_RESET = 8'h00;
  localparam logic [7:0] INT_VECTOR = 8'hff;
  localparam int STACK_DEPTH = 15;
  // Zero and carry flags travel together.
  typedef struct packed {
    logic zero;
    logic carry;
  } tcpu_flags_t;
  // Port address and output byte travel together.
  typedef struct packed {
    logic [7:0] id;
    logic [7:0] data;
  } tcpu_port_t;
  // One-hot execution phases.
  typedef enum logic [1:0] {
    S_EXEC = 2'b01,
    S_PORT = 2'b10
  } tcpu_state_t;
endpackage

// ### verif/tb.sv
// Self-checking bench for the tiny constant-coded CPU core.
`timescale 1ns/1ps
module tb
  import tcpu_pkg::*;
;
  logic ref_clk, rst, int_req, clr, rd_stb, wr_stb;
  logic [15:0] instr;
  logic [7:0] prog_addr, port_id, out_data, in_data;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] out_mem [256];
  logic [15:0] rom [256];
  int wr_count, rd_count, min_gap, errors, cmp_count;

  tcpu_core dut (.REF_CLK(ref_clk), .RST(rst), .INSTR(instr), .PROG_ADDR(prog_addr), .PORT_ID(port_id),
    .OUT_DATA(out_data), .IN_DATA(in_data), .READ_STROBE(rd_stb), .WRITE_STROBE(wr_stb), .INT_REQ(int_req),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  tcpu_periph periph (.clk(ref_clk), .rst(rst), .clr(clr), .port_id(port_id), .out_data(out_data),
    .read_strobe(rd_stb), .write_strobe(wr_stb), .in_data(in_data), .out_mem(out_mem),
    .wr_count(wr_count), .rd_count(rd_count), .min_gap(min_gap));

  // Clock at 100 MHz.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Synchronous program ROM with one edge of latency.
  always_ff @(posedge ref_clk) instr <= rom[prog_addr];

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One register write; handshakes are judged just before the edge that completes them.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ha, hw, hb;
    n = 0;
    hb = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb && n < 50)
    begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      if (hb) r = bresp;
      @(posedge ref_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      n++;
    end
    @(posedge ref_clk); // The release edge passes before any next request.
    if (!hb) errors++;
  endtask

  // One register read.
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ha, hr;
    n = 0;
    hr = 1'b0;
    d = '0;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 50)
    begin
      @(negedge ref_clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      if (hr)
      begin
        d = rdata;
        r = rresp;
      end
      @(posedge ref_clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      n++;
    end
    @(posedge ref_clk); // The release edge passes before any next request.
    if (!hr) errors++;
  endtask

  // Copies a program fragment into the ROM.
  task automatic load(input logic [7:0] base, input logic [15:0] w [$]);
    foreach (w[i]) rom[base + i[7:0]] = w[i];
  endtask

  // Restarts the core through the soft reset, clears the log and lets it run.
  task automatic run_prog(input int cyc);
    logic [1:0] r;
    axi_wr(REG_CTRL, 32'h3, r);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
  endtask

  // Register access kinds, unmapped address and masked interrupt after reset.
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(REG_CTRL, d, r);
    chk(d, 32'h1);
    axi_rd(4'h8, d, r);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    axi_wr(REG_STATUS, 32'hffffffff, r);
    chk(r, RESP_OKAY);
    axi_rd(REG_STATUS, d, r);
    chk(d[STAT_IE_BIT], 1'b0);
    $display("test regs done");
  endtask

  // Arithmetic, logic, shift and port traffic, with the interrupt request held but masked.
  task automatic t_alu;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] pt [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h50, 8'h51};
    logic [7:0] ex [9] = '{8'h10, 8'h02, 8'hff, 8'h0f, 8'hb3, 8'hb2, 8'h59, 8'h18, 8'h39};
    load(8'h00, {16'h0af0, 16'h0b01, 16'h4a20, 16'h5b00, 16'hea10, 16'heb11, 16'h6b03, 16'h7a00,
      16'heb12, 16'hea13, 16'h1a3c, 16'h2a40, 16'h3aff, 16'hea14, 16'h0f15, 16'hcab4, 16'hfaf0,
      16'hda0e, 16'hea16, 16'ha742, 16'h0863, 16'hb980, 16'he750, 16'he951, 16'h8118});
    int_req <= 1'b1;
    run_prog(70);
    int_req <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) chk(out_mem[pt[i]], ex[i]);
    chk(wr_count, 9);
    chk(rd_count, 2);
    chk(min_gap, 2);
    axi_rd(REG_STATUS, d, r);
    chk(d[10:0], 11'h018);
    $display("test alu done");
  endtask

  // Conditional jumps, a skipped call, a call and a conditional return.
  task automatic t_flow;
    logic [31:0] d;
    logic [1:0] r;
    load(8'h00, {16'h1000, 16'h9505, 16'h9104, 16'he0ee, 16'h9b30, 16'h8320, 16'he121, 16'h8107});
    load(8'h20, {16'h0155, 16'h9c80, 16'he0ee});
    load(8'h30, {16'he0ee});
    run_prog(40);
    chk(out_mem[8'h21], 8'h55);
    chk(out_mem[8'hee], 8'h00);
    chk(wr_count, 1);
    axi_rd(REG_STATUS, d, r);
    chk(d[10:0], 11'h107);
    $display("test flow done");
  endtask

  // Every shift and rotate kind but the zero-fill right shift on one register, each result written out.
  task automatic t_shift;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ex [9] = '{8'hc0, 8'h81, 8'hc0, 8'h81, 8'h03, 8'h81, 8'hc0, 8'h81, 8'h02};
    load(8'h00, {16'h0181, 16'hd10c, 16'he160, 16'hd100, 16'he161, 16'hd10a, 16'he162, 16'hd102,
      16'he163, 16'hd104, 16'he164, 16'hd108, 16'he165, 16'hd10f, 16'he166, 16'hd107, 16'he167,
      16'hd106, 16'he168, 16'h8113});
    run_prog(50);
    for (int i = 0; i < 9; i++) chk(out_mem[8'h60 + i[7:0]], ex[i]);
    axi_rd(REG_STATUS, d, r);
    chk(d[10:0], 11'h213);
    $display("test shift done");
  endtask

  // Interrupt taken once, serviced at the top address and returned from with flags restored.
  task automatic t_irq;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    load(8'h00, {16'h03ff, 16'h4301, 16'h02a5, 16'h8030, 16'h8104});
    load(8'h40, {16'h3201, 16'he230, 16'h0000, 16'h0000, 16'h0000, 16'h80f0});
    load(8'hff, {16'h8140});
    run_prog(20);
    axi_rd(REG_STATUS, d, r);
    chk(d[10:8], 3'b111);
    int_req <= 1'b1;
    n = 0;
    while (wr_count == 0 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    int_req <= 1'b0;
    repeat (30) @(posedge ref_clk);
    chk(out_mem[8'h30], 8'ha4);
    chk(wr_count, 1);
    axi_rd(REG_STATUS, d, r);
    chk(d[10:0], 11'h704);
    $display("test irq done");
  endtask

  // Watchdog against a hang.
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired at %0t", $time);
    end_sim;
  end

  // Main sequence.
  initial
  begin
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    int_req = 1'b0;
    clr = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    foreach (rom[i]) rom[i] = 16'h0000;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs;
    t_alu;
    t_flow;
    t_shift;
    t_irq;
    end_sim;
  end
endmodule

// ### verif/tcpu_periph.sv
// Port-bus peripheral model that logs output writes and answers input reads.
`timescale 1ns/1ps
module tcpu_periph
  import tcpu_pkg::*;
(
  // Clock, reset and log clear.
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Port bus from the core.
  input wire logic [7:0] port_id,
  input wire logic [7:0] out_data,
  input wire logic read_strobe,
  input wire logic write_strobe,
  output logic [7:0] in_data,
  // Log seen by the bench.
  output logic [7:0] out_mem [256],
  output int wr_count,
  output int rd_count,
  output int min_gap
);
  int cyc;
  int last_wr;
  // The input byte follows the port address; it is inverted while no read is under way.
  assign in_data = read_strobe ? (port_id ^ 8'h5a) : ~(port_id ^ 8'h5a);
  // Output bytes are latched only when the write strobe qualifies them.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst || clr)
    begin
      wr_count <= 0;
      rd_count <= 0;
      min_gap <= 1000;
      last_wr <= -1000;
      cyc <= 0;
      foreach (out_mem[i]) out_mem[i] <= 8'h00;
    end
    else
    begin
      cyc <= cyc + 1;
      if (write_strobe)
      begin
        out_mem[port_id] <= out_data;
        wr_count <= wr_count + 1;
        last_wr <= cyc;
        if (cyc - last_wr < min_gap) min_gap <= cyc - last_wr;
      end
      if (read_strobe) rd_count <= rd_count + 1;
    end
  end
endmodule
